// file: hdl/cmrro_core.sv
// Execution unit for move, no-op, return and rotate-left operations.
// Assumes the decoder holds instr stable while instr_valid and busy are high,
// and the register file answers rf_rdata combinationally from rf_raddr.
`timescale 1ns/10ps
`include "cmrro_cfg.svh"

// Notes on behaviour
// - Acc copied to file, flags untouched, one cycle
// - File move goes to acc or back
// - File move sets zero flag, one cycle
// - No-op only advances program counter, one cycle
// - Immediate return loads acc, pops, sets enable
// - Interrupt return pops stack, sets enable, two
// - Plain return pops, enable kept, two cycles
// - Rotate left: carry in bit0, bit7 out
// - Rotate result to acc or file register
module cmrro_core #(
    parameter int DEPTH = 8                           // Hardware stack depth
) (
    input  wire logic                       clk_sys,       // 250 MHz core clock
    input  wire logic                       rst,           // Async reset, active high
    input  wire logic                       instr_valid,   // Instruction present
    input  wire cmrro_pkg::cmrro_instr_t    instr,         // Decoded instruction
    input  wire logic [`CMRRO_DATA_W-1:0]   rf_rdata,      // File register read data
    input  wire logic                       push_en,       // Call pushes a return address
    input  wire logic [`CMRRO_PC_W-1:0]     push_pc,       // Return address to push
    output logic [`CMRRO_ADDR_W-1:0]        rf_raddr,      // File register read address
    output cmrro_pkg::cmrro_wr_t            rf_wr,         // File register write
    output logic                            busy,          // Two-cycle op in progress
    output logic                            done,          // Instruction retires
    output logic [`CMRRO_DATA_W-1:0]        acc_q,         // Accumulator
    output logic                            zero_q,        // Zero flag
    output logic                            carry_q,       // Carry flag
    output logic                            global_interrupt_enable_q, // Interrupt enable
    output logic [`CMRRO_PC_W-1:0]          pc_q,          // Program counter
    output logic [`CMRRO_SP_W-1:0]          sp_q           // Stack level
);

    // ****************************************
    // Decode and datapath
    // ****************************************
    cmrro_pkg::cmrro_state_t state_q;
    logic [`CMRRO_PC_W-1:0]  stack_q [DEPTH];
    logic                    is_return;
    logic                    go;
    logic [`CMRRO_DATA_W-1:0] rot_val;
    logic [`CMRRO_SP_W-1:0]  top_idx;

    assign rf_raddr  = instr.addr;
    assign is_return = (instr.op == cmrro_pkg::OP_RETURN_IMM)
                    || (instr.op == cmrro_pkg::OP_RETURN_INT)
                    || (instr.op == cmrro_pkg::OP_RETURN_SUB);
    assign go        = instr_valid && (state_q == cmrro_pkg::ST_EXEC);
    assign rot_val   = {rf_rdata[6:0], carry_q};
    assign top_idx   = sp_q - `CMRRO_SP_W'(1);
    // Returns occupy a second cycle after the pop completes at the taking edge
    assign busy      = (state_q == cmrro_pkg::ST_POP) || (go && is_return);
    assign done      = (go && !is_return) || (state_q == cmrro_pkg::ST_POP);

    // File register write port, combinational handshake-style strobe
    always_comb begin
        rf_wr = '0;
        rf_wr.addr = instr.addr;
        if (go) begin
            unique case (instr.op)
                cmrro_pkg::OP_ACC_TO_FILE: begin
                    rf_wr.we   = 1'b1;
                    rf_wr.data = acc_q;
                end
                cmrro_pkg::OP_FILE_MOVE: begin
                    rf_wr.we   = instr.dest;
                    rf_wr.data = rf_rdata;
                end
                cmrro_pkg::OP_ROTATE_LEFT: begin
                    rf_wr.we   = instr.dest;
                    rf_wr.data = rot_val;
                end
                default: rf_wr.we = 1'b0;
            endcase
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= cmrro_pkg::ST_EXEC;
        end else begin
            unique case (state_q)
                // Pop cycle is a bubble: the return's registers moved at the taking edge
                cmrro_pkg::ST_EXEC: if (go && is_return) state_q <= cmrro_pkg::ST_POP;
                cmrro_pkg::ST_POP:  state_q <= cmrro_pkg::ST_EXEC;
            endcase
        end
    end

    // Accumulator
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_q <= `CMRRO_ACC_RST;
        end else if (go) begin
            if (instr.op == cmrro_pkg::OP_FILE_MOVE && !instr.dest) acc_q <= rf_rdata;
            if (instr.op == cmrro_pkg::OP_ROTATE_LEFT && !instr.dest) acc_q <= rot_val;
            if (instr.op == cmrro_pkg::OP_RETURN_IMM) acc_q <= instr.imm;
        end
    end

    // Flags; only file move and rotate touch them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            zero_q  <= 1'b0;
            carry_q <= 1'b0;
        end else if (go) begin
            if (instr.op == cmrro_pkg::OP_FILE_MOVE) zero_q <= (rf_rdata == '0);
            if (instr.op == cmrro_pkg::OP_ROTATE_LEFT) carry_q <= rf_rdata[7];
        end
    end

    // Global interrupt enable, set at the pop of the enabling returns
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            global_interrupt_enable_q <= 1'b0;
        end else if (go && (instr.op == cmrro_pkg::OP_RETURN_IMM
                            || instr.op == cmrro_pkg::OP_RETURN_INT)) begin
            global_interrupt_enable_q <= 1'b1;
        end
    end

    // Program counter: single-cycle ops step, returns load top of stack
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_q <= `CMRRO_PC_RST;
        end else if (go && !is_return) begin
            pc_q <= pc_q + `CMRRO_PC_W'(1);
        end else if (go && is_return) begin
            pc_q <= stack_q[top_idx];
        end
    end

    // Stack pointer; underflow is not guarded, caller keeps calls and returns paired
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sp_q <= '0;
        end else if (go && is_return) begin
            sp_q <= top_idx;
        end else if (push_en) begin
            sp_q <= sp_q + `CMRRO_SP_W'(1);
        end
    end

    // Stack storage, written only by pushes
    always_ff @(posedge clk_sys) begin
        if (push_en && !(go && is_return)) stack_q[sp_q] <= push_pc;
    end

    // ****************************************
    // Assertions
    // ****************************************
    // Second-cycle checks use busy and done rather than state_q, so that a
    // change of state encoding leaves them valid
    AST_ACC_TO_FILE_WR: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_ACC_TO_FILE |-> rf_wr.we && rf_wr.data == acc_q
        ##1 acc_q == $past(acc_q) && zero_q == $past(zero_q) && carry_q == $past(carry_q))
        else $error("acc to file move wrong");
    AST_ACC_TO_FILE_ONE: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_ACC_TO_FILE |-> done && !busy
        && rf_wr.addr == instr.addr)
        else $error("acc to file move length or address wrong");
    AST_FILE_MOVE_DEST: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_FILE_MOVE && !instr.dest |=> acc_q == $past(rf_rdata))
        else $error("file move to acc wrong");
    AST_FILE_MOVE_BACK: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_FILE_MOVE && instr.dest |-> rf_wr.we
        && rf_wr.data == rf_rdata ##1 acc_q == $past(acc_q))
        else $error("file move write back wrong");
    AST_FILE_MOVE_Z: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_FILE_MOVE |=> zero_q == ($past(rf_rdata) == 8'h00))
        else $error("zero flag wrong");
    AST_FILE_MOVE_ONE: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_FILE_MOVE |-> done && !busy)
        else $error("file move length wrong");
    AST_NOP: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_NOP |-> done && !rf_wr.we
        ##1 pc_q == $past(pc_q) + 10'h001 && acc_q == $past(acc_q))
        else $error("no-op wrong");
    AST_NOP_KEEP: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_NOP |=> zero_q == $past(zero_q)
        && carry_q == $past(carry_q) && sp_q == $past(sp_q)
        && global_interrupt_enable_q == $past(global_interrupt_enable_q))
        else $error("no-op changed state");
    AST_RETURN_IMM: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_RETURN_IMM |=> acc_q == $past(instr.imm)
        && global_interrupt_enable_q && sp_q == $past(sp_q) - 3'h1 && done)
        else $error("immediate return wrong");
    AST_RETURN_IMM_PC: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_RETURN_IMM |-> busy && !done
        ##1 busy && done && pc_q == $past(stack_q[top_idx]))
        else $error("immediate return pop wrong");
    AST_RETURN_INT: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_RETURN_INT |-> busy && !done
        ##1 busy && done && global_interrupt_enable_q ##1 !(busy && done))
        else $error("interrupt return wrong");
    AST_RETURN_INT_POP: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_RETURN_INT |=> sp_q == $past(sp_q) - 3'h1
        && pc_q == $past(stack_q[top_idx]))
        else $error("interrupt return pop wrong");
    AST_RETURN_SUB: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_RETURN_SUB |=> $stable(global_interrupt_enable_q)
        && sp_q == $past(sp_q) - 3'h1 && done)
        else $error("plain return wrong");
    AST_RETURN_SUB_LEN: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_RETURN_SUB |-> busy && !done
        ##1 busy && done && pc_q == $past(stack_q[top_idx]))
        else $error("plain return pop wrong");
    AST_ROTATE_CARRY: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_ROTATE_LEFT |=> carry_q == $past(rf_rdata[7]))
        else $error("rotate carry wrong");
    AST_ROTATE_ACC: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_ROTATE_LEFT && !instr.dest |-> !rf_wr.we && done
        ##1 acc_q == {$past(rf_rdata[6:0]), $past(carry_q)})
        else $error("rotate to acc wrong");
    AST_ROTATE_DEST: assert property (@(posedge clk_sys) disable iff (rst)
        go && instr.op == cmrro_pkg::OP_ROTATE_LEFT && instr.dest |-> rf_wr.we
        && rf_wr.data == {rf_rdata[6:0], carry_q})
        else $error("rotate writeback wrong");

endmodule // cmrro_core

// file: inc/cmrro_cfg.svh
// Constants for the move, return and rotate execution unit.
// Assumes inclusion by bare name from the package and design files.
`ifndef CMRRO_CFG_SVH
`define CMRRO_CFG_SVH
`define CMRRO_DATA_W      8
`define CMRRO_ADDR_W      6
`define CMRRO_PC_W        10
`define CMRRO_SP_W        3
`define CMRRO_ACC_RST     8'h00
`define CMRRO_PC_RST      10'h000
`define CMRRO_ZBIT        2
`define CMRRO_CBIT        0
`define CMRRO_CYC_ONE     2'h1
`define CMRRO_CYC_TWO     2'h2
`define CMRRO_OP_W        3
`endif

// file: inc/cmrro_pkg.sv
// Types for the move, return and rotate execution unit.
// Assumes cmrro_cfg.svh is on the include path.
`include "cmrro_cfg.svh"
package cmrro_pkg;
    // Decoded operation codes handed in by the decoder
    typedef enum logic [`CMRRO_OP_W-1:0] {
        OP_NOP         = 3'h0,
        OP_ACC_TO_FILE = 3'h1,
        OP_FILE_MOVE   = 3'h2,
        OP_RETURN_IMM  = 3'h3,
        OP_RETURN_INT  = 3'h4,
        OP_RETURN_SUB  = 3'h5,
        OP_ROTATE_LEFT = 3'h6
    } cmrro_op_t;

    // Decoded instruction
    typedef struct packed {
        cmrro_op_t                 op;
        logic [`CMRRO_ADDR_W-1:0]  addr;
        logic                      dest;
        logic [`CMRRO_DATA_W-1:0]  imm;
    } cmrro_instr_t;

    // Register file write request
    typedef struct packed {
        logic                      we;
        logic [`CMRRO_ADDR_W-1:0]  addr;
        logic [`CMRRO_DATA_W-1:0]  data;
    } cmrro_wr_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_EXEC = 2'b01,
        ST_POP  = 2'b10
    } cmrro_state_t;
endpackage

// file: tb/test_cmrro_core.sv
// Self-checking bench for the move, return and rotate execution unit.
// Assumes cmrro_pkg and cmrro_core are compiled first; drives ports at the falling edge.
`timescale 1ns/10ps
`include "cmrro_cfg.svh"
module test_cmrro_core;
    logic                     clk_sys;         // Core clock
    logic                     rst;             // Async reset
    logic                     instr_valid;     // Instruction present
    cmrro_pkg::cmrro_instr_t  instr;           // Decoded instruction
    logic [7:0]               rf_rdata;        // File read data
    logic                     push_en;         // Call push strobe
    logic [9:0]               push_pc;         // Pushed address
    logic [5:0]               rf_raddr;        // File read address
    cmrro_pkg::cmrro_wr_t     rf_wr;           // File write
    logic                     busy;            // Return in progress
    logic                     done;            // Retire strobe
    logic [7:0]               acc_q;           // Accumulator
    logic                     zero_q;          // Zero flag
    logic                     carry_q;         // Carry flag
    logic                     global_interrupt_enable_q; // Interrupt enable
    logic [9:0]               pc_q;            // Program counter
    logic [2:0]               sp_q;            // Stack level
    cmrro_pkg::cmrro_wr_t     wr_s;            // Write seen in execute cycle
    logic                     b0;              // Busy seen in execute cycle
    int                       error_cnt;       // Mismatches
    int                       samples_checked; // Comparisons

    cmrro_core dut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .rf_rdata(rf_rdata), .push_en(push_en), .push_pc(push_pc), .rf_raddr(rf_raddr),
        .rf_wr(rf_wr), .busy(busy), .done(done), .acc_q(acc_q), .zero_q(zero_q),
        .carry_q(carry_q), .global_interrupt_enable_q(global_interrupt_enable_q),
        .pc_q(pc_q), .sp_q(sp_q));

    // Free-running 4 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Call side pushes one return address
    task automatic push(input logic [9:0] p);
        @(negedge clk_sys);
        push_en = 1'b1;
        push_pc = p;
        @(negedge clk_sys);
        push_en = 1'b0;
    endtask

    // Issue one instruction, hold it until it retires, check its length
    task automatic run(input cmrro_pkg::cmrro_op_t op, input logic [5:0] a, input logic d,
                       input logic [7:0] im, input logic [7:0] rd, input int ncyc);
        int n;
        @(negedge clk_sys);
        instr_valid = 1'b1;
        instr = '{op: op, addr: a, dest: d, imm: im};
        rf_rdata = rd;
        #1;
        wr_s = rf_wr;
        b0 = busy;
        chk({10'h0, rf_raddr}, {10'h0, a});
        n = 1;
        // Bounded so a missing retire cannot hang the run
        while (done !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            @(negedge clk_sys);
            #1;
            n++;
        end
        if (done !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
        chk(16'(n), 16'(ncyc));
        chk({15'h0, b0}, {15'h0, ncyc > 1});
        @(posedge clk_sys);
        @(negedge clk_sys);
        instr_valid = 1'b0;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic s_returns();
        push(10'h123);
        push(10'h2a5);
        run(cmrro_pkg::OP_RETURN_SUB, 6'h00, 1'b0, 8'h00, 8'h00, 2);
        chk({6'h0, pc_q}, 16'h02a5);
        chk({13'h0, sp_q}, 16'h0001);
        chk({15'h0, global_interrupt_enable_q}, 16'h0000);
        push(10'h0f0);
        run(cmrro_pkg::OP_RETURN_INT, 6'h00, 1'b0, 8'h00, 8'h00, 2);
        chk({5'h0, global_interrupt_enable_q, pc_q}, 16'h04f0);
        chk({13'h0, sp_q}, 16'h0001);
        run(cmrro_pkg::OP_RETURN_IMM, 6'h00, 1'b0, 8'h55, 8'h00, 2);
        chk({5'h0, global_interrupt_enable_q, pc_q}, 16'h0523);
        chk({8'h0, acc_q}, 16'h0055);
        chk({13'h0, sp_q}, 16'h0000);
        run(cmrro_pkg::OP_NOP, 6'h00, 1'b0, 8'h00, 8'h00, 1);
        chk({6'h0, pc_q}, 16'h0124);
        chk({8'h0, acc_q}, 16'h0055);
        chk({15'h0, wr_s.we}, 16'h0000);
    endtask

    task automatic s_moves();
        run(cmrro_pkg::OP_FILE_MOVE, 6'h05, 1'b1, 8'h00, 8'h00, 1);
        chk(16'(wr_s), {1'b0, 1'b1, 6'h05, 8'h00});
        chk({7'h0, zero_q, acc_q}, 16'h0155);
        // Zero flag is set here, so a move that disturbed flags would show
        run(cmrro_pkg::OP_ACC_TO_FILE, 6'h3f, 1'b0, 8'h00, 8'h77, 1);
        chk(16'(wr_s), {1'b0, 1'b1, 6'h3f, 8'h55});
        chk({6'h0, zero_q, carry_q, acc_q}, 16'h0255);
        run(cmrro_pkg::OP_FILE_MOVE, 6'h09, 1'b0, 8'h00, 8'h3c, 1);
        chk({7'h0, zero_q, acc_q}, 16'h003c);
        chk({15'h0, wr_s.we}, 16'h0000);
    endtask

    task automatic s_rotate();
        run(cmrro_pkg::OP_ROTATE_LEFT, 6'h07, 1'b1, 8'h00, 8'ha5, 1);
        chk(16'(wr_s), {1'b0, 1'b1, 6'h07, 8'h4a});
        chk({7'h0, carry_q, acc_q}, 16'h013c);
        run(cmrro_pkg::OP_ROTATE_LEFT, 6'h07, 1'b0, 8'h00, 8'h01, 1);
        chk({7'h0, carry_q, acc_q}, 16'h0003);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        rf_rdata = 8'h00;
        push_en = 1'b0;
        push_pc = 10'h000;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        s_returns();
        s_moves();
        s_rotate();
        report_and_stop();
    end
endmodule // test_cmrro_core
